// ===== dv/host_port_forwarding_control_test.sv
`timescale 1ns/1ps
module host_port_forwarding_control_test;
  import host_port_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic rx_pkt_valid = 1'b0;
  logic [2:0] rx_pkt_dest = 3'h0;
  logic [2:0] rx_pkt_prio = 3'h0;
  logic [2:0] default_prio = 3'h0;
  logic [2:0] sniffer_dest = 3'h0;
  logic fwd_valid, fwd_monitored, learn_strobe, tx_grant, tx_mirror, mon_grant;
  logic [2:0] fwd_mask, fwd_prio, vlan_member;
  logic tx_req = 1'b0;
  logic mon_req = 1'b0;
  logic tx_enable, rx_enable, learn_disable, sniffer_port, rx_sniff, tx_sniff, prio_ceiling;
  logic [15:0] d;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  host_port_forwarding_control i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_dest(rx_pkt_dest), .rx_pkt_prio(rx_pkt_prio),
    .default_prio(default_prio), .sniffer_dest(sniffer_dest), .fwd_valid(fwd_valid),
    .fwd_mask(fwd_mask), .fwd_prio(fwd_prio), .fwd_monitored(fwd_monitored),
    .learn_strobe(learn_strobe), .tx_req(tx_req), .mon_req(mon_req), .tx_grant(tx_grant),
    .tx_mirror(tx_mirror), .mon_grant(mon_grant), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .learn_disable(learn_disable), .sniffer_port(sniffer_port),
    .rx_sniff(rx_sniff), .tx_sniff(tx_sniff), .prio_ceiling(prio_ceiling),
    .vlan_member(vlan_member));

  // 125 mhz clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: the tests need well under a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end

  task conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles; read data is only looked at in the cycle after the strobe
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // one packet in, decision sampled one cycle later
  task pkt(input logic [2:0] dst, input logic [2:0] pr, input logic [2:0] df,
           input logic [2:0] sn);
    @(posedge ref_clk);
    rx_pkt_valid <= 1'b1;
    rx_pkt_dest <= dst;
    rx_pkt_prio <= pr;
    default_prio <= df;
    sniffer_dest <= sn;
    @(posedge ref_clk);
    rx_pkt_valid <= 1'b0;
    #1 d = {7'h00, fwd_valid, fwd_mask, fwd_prio, fwd_monitored, learn_strobe};
  endtask : pkt

  task req(input logic t, input logic m);
    @(posedge ref_clk);
    tx_req <= t;
    mon_req <= m;
    @(posedge ref_clk);
    tx_req <= 1'b0;
    mon_req <= 1'b0;
    #1 d = {13'h0000, tx_grant, tx_mirror, mon_grant};
  endtask : req

  ////////////////////////////////////////////////////////////////////////////////
  task test_reset();
    rd(4'h2, d);
    check(d, 16'h0607);
    check({6'h00, tx_enable, rx_enable, learn_disable, sniffer_port, rx_sniff, tx_sniff,
           prio_ceiling, vlan_member}, 16'h0307);
    $display("test_reset done");
  endtask : test_reset

  task test_regs();
    wr(4'h2, 16'hffff);
    rd(4'h2, d);
    check(d, 16'h07ff);
    check({8'h00, learn_disable, sniffer_port, rx_sniff, tx_sniff, prio_ceiling,
           vlan_member}, 16'h00ff);
    wr(4'h6, 16'h1234);
    rd(4'h6, d);
    check(d, 16'h0000);
    rd(4'h2, d);
    check(d, 16'h07ff);
    $display("test_regs done");
  endtask : test_regs

  task test_rx();
    // ceiling on, reserved bit set, host and port one members only
    wr(4'h2, 16'h061d);
    pkt(3'b011, 3'h6, 3'h2, 3'b000);
    check(d, {7'h00, 1'b1, 3'b001, 3'h2, 1'b0, 1'b1});
    // receive disabled must drop the packet and skip learning
    wr(4'h2, 16'h0547);
    pkt(3'b001, 3'h5, 3'h1, 3'b010);
    check(d, 16'h0000);
    check({14'h0000, tx_enable, rx_enable}, 16'h0002);
    // receive sniff with learning off, no ceiling
    wr(4'h2, 16'h0747);
    pkt(3'b001, 3'h5, 3'h1, 3'b010);
    check(d, {7'h00, 1'b1, 3'b011, 3'h5, 1'b1, 1'b0});
    $display("test_rx done");
  endtask : test_rx

  task test_tx();
    wr(4'h2, 16'h0620);
    req(1'b1, 1'b1);
    check(d, 16'h0006);
    wr(4'h2, 16'h06a0);
    req(1'b0, 1'b1);
    check(d, 16'h0001);
    wr(4'h2, 16'h02a0);
    req(1'b1, 1'b1);
    check(d, 16'h0000);
    check({14'h0000, tx_enable, rx_enable}, 16'h0001);
    $display("test_tx done");
  endtask : test_tx

  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    test_reset();
    test_regs();
    test_rx();
    test_tx();
    conclude();
  end
endmodule : host_port_forwarding_control_test

// ===== logic/host_port_ctrl_pkg.sv
package host_port_ctrl_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets within the bank
  localparam logic [3:0] HOST_PORT_CONTROL_TWO_OFS = 4'h2;
  localparam logic [3:0] HOST_PORT_VID_CONTROL_OFS = 4'h4;
  localparam logic [3:0] HOST_PORT_CONTROL_THREE_OFS = 4'h6;
  localparam logic [3:0] HOST_PORT_INGRESS_RATE_OFS = 4'h8;
  localparam logic [3:0] HOST_PORT_EGRESS_RATE_OFS = 4'ha;
  localparam logic [3:0] BANK_SELECT_OFS = 4'he;

  // field positions in host_port_control_two
  localparam int TX_ENABLE_BIT = 10;
  localparam int RX_ENABLE_BIT = 9;
  localparam int LEARN_DISABLE_BIT = 8;
  localparam int SNIFFER_PORT_BIT = 7;
  localparam int RX_SNIFF_BIT = 6;
  localparam int TX_SNIFF_BIT = 5;
  localparam int SPARE_BIT = 4;
  localparam int PRIO_CEILING_BIT = 3;
  localparam int MEMBER_MSB = 2;
  localparam int MEMBER_LSB = 0;

  // bits that hold storage; reserved bits outside read as zero
  localparam logic [15:0] CONTROL_TWO_RW_MASK = 16'h07ff;
  // transmit and receive on, full membership, everything else off
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h0607;

  // membership bit per destination
  localparam int PORT_ONE_IDX = 0;
  localparam int PORT_TWO_IDX = 1;
  localparam int HOST_PORT_IDX = 2;

endpackage : host_port_ctrl_pkg

// ===== logic/host_port_forwarding_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - transmit enable high lets the host port send; low blocks all transmission.
// - receive enable, bit 9, resets high; low means no packet is accepted.
// - learning disable, bit 8, resets low; high stops source address learning.
// - bit 7 makes the port the mirror destination for monitored packets.
// - bit 6 marks every received packet monitored and copies it to the mirror port when that port's membership bit is set.
// - bit 5 marks every transmitted packet monitored and sends it to the mirror port.
// - bit 3 clamps packet user priority to the port default tag priority.
// - three-bit membership resets to 0x7; bit2 host, bit1 port two, bit0 port one.
// - received packets go only to ports whose membership bit is set.
// - bit 4 is reserved, resets low and changes no forwarding behaviour.
module host_port_forwarding_control
  import host_port_ctrl_pkg::*;
#(
  parameter int PRIO_W = 3,
  parameter int PORTS = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // packets received on the host port, one cycle each
  input wire logic rx_pkt_valid,
  input wire logic [PORTS-1:0] rx_pkt_dest,
  input wire logic [PRIO_W-1:0] rx_pkt_prio,
  input wire logic [PRIO_W-1:0] default_prio,
  input wire logic [PORTS-1:0] sniffer_dest,
  // forwarding decision for the received packet
  output logic fwd_valid,
  output logic [PORTS-1:0] fwd_mask,
  output logic [PRIO_W-1:0] fwd_prio,
  output logic fwd_monitored,
  output logic learn_strobe,
  // packets offered for transmission out of the host port
  input wire logic tx_req,
  input wire logic mon_req,
  output logic tx_grant,
  output logic tx_mirror,
  output logic mon_grant,
  // live configuration for the switch fabric
  output logic tx_enable,
  output logic rx_enable,
  output logic learn_disable,
  output logic sniffer_port,
  output logic rx_sniff,
  output logic tx_sniff,
  output logic prio_ceiling,
  output logic [PORTS-1:0] vlan_member
);

  //////////////////////////////////////////////////////////////////////////////
  // register access decode

  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] ctrl_view;
  logic hit_ctrl;
  logic wr_ctrl;

  // keeps only the implemented bits, so writes and reads agree on what is stored
  function automatic logic [DATA_W-1:0] stored_bits(input logic [DATA_W-1:0] word);
    return word & CONTROL_TWO_RW_MASK;
  endfunction : stored_bits

  // unmapped offsets and the bank's other registers read as zero here
  assign hit_ctrl = (reg_addr == HOST_PORT_CONTROL_TWO_OFS);
  assign wr_ctrl = reg_wr && hit_ctrl;
  assign ctrl_nxt = wr_ctrl ? stored_bits(reg_wdata) : ctrl_r;
  assign ctrl_view = stored_bits(ctrl_r);
  assign rdata_nxt = (reg_rd && hit_ctrl) ? ctrl_view : '0;

  // storage; the reset value carries the documented defaults
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CONTROL_TWO_RESET;
      reg_rdata <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field extraction

  logic f_tx_en;
  logic f_rx_en;
  logic f_learn_dis;
  logic f_sniffer;
  logic f_rx_sniff;
  logic f_tx_sniff;
  logic f_ceiling;
  logic [PORTS-1:0] f_member;

  // the spare bit is stored for readback only and steers nothing
  assign f_tx_en = ctrl_r[TX_ENABLE_BIT];
  assign f_rx_en = ctrl_r[RX_ENABLE_BIT];
  assign f_learn_dis = ctrl_r[LEARN_DISABLE_BIT];
  assign f_sniffer = ctrl_r[SNIFFER_PORT_BIT];
  assign f_rx_sniff = ctrl_r[RX_SNIFF_BIT];
  assign f_tx_sniff = ctrl_r[TX_SNIFF_BIT];
  assign f_ceiling = ctrl_r[PRIO_CEILING_BIT];
  assign f_member = ctrl_r[MEMBER_MSB:MEMBER_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // receive path decision

  logic rx_take;
  logic [PORTS-1:0] rx_targets;
  logic [PORTS-1:0] mask_nxt;
  logic [PRIO_W-1:0] prio_nxt;
  logic clamp_hit;

  assign rx_take = rx_pkt_valid && f_rx_en;
  // mirror copies obey membership too, so no excluded port sees a packet
  assign rx_targets = rx_pkt_dest | (f_rx_sniff ? sniffer_dest : '0);
  assign mask_nxt = rx_take ? (rx_targets & f_member) : '0;
  assign clamp_hit = f_ceiling && (rx_pkt_prio > default_prio);
  assign prio_nxt = clamp_hit ? default_prio : rx_pkt_prio;

  // one stage of flops keeps every fabric-facing output glitch free
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fwd_valid <= 1'b0;
      fwd_mask <= '0;
      fwd_prio <= '0;
      fwd_monitored <= 1'b0;
      learn_strobe <= 1'b0;
    end else begin
      fwd_valid <= rx_take;
      fwd_mask <= mask_nxt;
      fwd_prio <= rx_take ? prio_nxt : '0;
      fwd_monitored <= rx_take && f_rx_sniff;
      learn_strobe <= rx_take && !f_learn_dis;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit path gating

  logic tx_ok;
  logic mon_ok;

  assign tx_ok = tx_req && f_tx_en;
  // monitored traffic only leaves a port that is both sniffer and enabled
  assign mon_ok = mon_req && f_sniffer && f_tx_en;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_grant <= 1'b0;
      tx_mirror <= 1'b0;
      mon_grant <= 1'b0;
    end else begin
      tx_grant <= tx_ok;
      tx_mirror <= tx_ok && f_tx_sniff;
      mon_grant <= mon_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration outputs, delayed one cycle behind the register

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_enable <= CONTROL_TWO_RESET[TX_ENABLE_BIT];
      rx_enable <= CONTROL_TWO_RESET[RX_ENABLE_BIT];
      learn_disable <= CONTROL_TWO_RESET[LEARN_DISABLE_BIT];
      sniffer_port <= CONTROL_TWO_RESET[SNIFFER_PORT_BIT];
      rx_sniff <= CONTROL_TWO_RESET[RX_SNIFF_BIT];
      tx_sniff <= CONTROL_TWO_RESET[TX_SNIFF_BIT];
      prio_ceiling <= CONTROL_TWO_RESET[PRIO_CEILING_BIT];
      vlan_member <= CONTROL_TWO_RESET[MEMBER_MSB:MEMBER_LSB];
    end else begin
      tx_enable <= f_tx_en;
      rx_enable <= f_rx_en;
      learn_disable <= f_learn_dis;
      sniffer_port <= f_sniffer;
      rx_sniff <= f_rx_sniff;
      tx_sniff <= f_tx_sniff;
      prio_ceiling <= f_ceiling;
      vlan_member <= f_member;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  a_tx_blocked: assert property (@(posedge ref_clk) disable iff (reset)
    tx_req && !f_tx_en |=> !tx_grant && !tx_mirror)
    else $error("transmit granted while transmit is disabled");

  a_tx_passes: assert property (@(posedge ref_clk) disable iff (reset)
    tx_req && f_tx_en |=> tx_grant)
    else $error("enabled transmit request not granted");

  a_rx_blocked: assert property (@(posedge ref_clk) disable iff (reset)
    rx_pkt_valid && !f_rx_en |=> !fwd_valid && fwd_mask == '0 && !learn_strobe)
    else $error("packet accepted while receive is disabled");

  a_learn_gate: assert property (@(posedge ref_clk) disable iff (reset)
    learn_strobe |-> fwd_valid && !$past(f_learn_dis))
    else $error("learning happened while disabled");

  a_sniffer_only: assert property (@(posedge ref_clk) disable iff (reset)
    mon_req && f_tx_en ##1 mon_grant |-> $past(f_sniffer))
    else $error("monitored packet sent from a non sniffer port");

  a_rx_mirror: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take |=> fwd_monitored == $past(f_rx_sniff)
      && ((fwd_mask ^ ($past(mask_nxt))) == '0))
    else $error("receive mirroring wrong");

  a_tx_mirror: assert property (@(posedge ref_clk) disable iff (reset)
    tx_mirror |-> tx_grant && $past(f_tx_sniff))
    else $error("transmit mirror without transmit sniff");

  a_prio_clamp: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && f_ceiling |=> fwd_prio <= $past(default_prio))
    else $error("priority above ceiling");

  a_prio_keep: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && !f_ceiling |=> fwd_prio == $past(rx_pkt_prio))
    else $error("priority changed without ceiling");

  a_member_only: assert property (@(posedge ref_clk) disable iff (reset)
    fwd_valid |-> (fwd_mask & ~$past(f_member)) == '0)
    else $error("packet sent to a port outside membership");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd |=> (reg_rdata & ~CONTROL_TWO_RW_MASK) == '0)
    else $error("reserved bits read nonzero");

  a_write_read: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ctrl ##1 (reg_rd && hit_ctrl)
      |=> reg_rdata == ($past(reg_wdata, 2) & CONTROL_TWO_RW_MASK))
    else $error("readback differs from write");

  a_write_acts: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ctrl ##1 tx_req |=> tx_grant == $past(reg_wdata[TX_ENABLE_BIT], 2))
    else $error("write did not steer next packet");

  a_tx_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !tx_req |=> !tx_grant && !tx_mirror)
    else $error("transmit granted without a request");

  a_rx_passes: assert property (@(posedge ref_clk) disable iff (reset)
    rx_pkt_valid && f_rx_en |=> fwd_valid)
    else $error("packet refused while receive is enabled");

  a_rx_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !rx_take |=> !fwd_valid && fwd_mask == '0 && fwd_prio == '0
      && !fwd_monitored && !learn_strobe)
    else $error("forwarding outputs active without an accepted packet");

  a_learn_on: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && !f_learn_dis |=> learn_strobe)
    else $error("learning skipped while enabled");

  a_learn_off: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && f_learn_dis |=> !learn_strobe)
    else $error("learning done while disabled");

  a_mon_blocked: assert property (@(posedge ref_clk) disable iff (reset)
    mon_req && !f_sniffer |=> !mon_grant)
    else $error("monitored packet sent from an ordinary port");

  a_mon_passes: assert property (@(posedge ref_clk) disable iff (reset)
    mon_req && f_sniffer && f_tx_en |=> mon_grant)
    else $error("sniffer port refused a monitored packet");

  a_rx_no_mirror: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && !f_rx_sniff |=> !fwd_monitored)
    else $error("packet marked monitored without receive sniff");

  a_tx_mirror_on: assert property (@(posedge ref_clk) disable iff (reset)
    tx_req && f_tx_en && f_tx_sniff |=> tx_mirror)
    else $error("transmitted packet not mirrored");

  a_tx_no_mirror: assert property (@(posedge ref_clk) disable iff (reset)
    tx_req && f_tx_en && !f_tx_sniff |=> !tx_mirror)
    else $error("transmitted packet mirrored without transmit sniff");

  a_prio_replace: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && f_ceiling && (rx_pkt_prio > default_prio) |=> fwd_prio == $past(default_prio))
    else $error("high priority not replaced by default");

  a_prio_below: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && f_ceiling && (rx_pkt_prio <= default_prio) |=> fwd_prio == $past(rx_pkt_prio))
    else $error("priority under the ceiling was changed");

  a_member_reach: assert property (@(posedge ref_clk) disable iff (reset)
    rx_take && !f_rx_sniff |=> fwd_mask == ($past(rx_pkt_dest) & $past(f_member)))
    else $error("member destination dropped");

  a_member_out: assert property (@(posedge ref_clk) disable iff (reset)
    vlan_member == $past(f_member))
    else $error("membership output does not follow the register");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");

  a_other_zero: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && !hit_ctrl |=> reg_rdata == '0)
    else $error("unmapped offset read nonzero");

  a_read_current: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && hit_ctrl |=> reg_rdata == ($past(ctrl_r) & CONTROL_TWO_RW_MASK))
    else $error("read data differ from stored value");

  // configuration copies lag the register by exactly one edge
  a_cfg_tx: assert property (@(posedge ref_clk) disable iff (reset)
    tx_enable == $past(f_tx_en))
    else $error("transmit enable output stale");

  a_cfg_rx: assert property (@(posedge ref_clk) disable iff (reset)
    rx_enable == $past(f_rx_en))
    else $error("receive enable output stale");

  a_cfg_learn: assert property (@(posedge ref_clk) disable iff (reset)
    learn_disable == $past(f_learn_dis))
    else $error("learning disable output stale");

  a_cfg_sniffer: assert property (@(posedge ref_clk) disable iff (reset)
    sniffer_port == $past(f_sniffer))
    else $error("sniffer port output stale");

  a_cfg_rx_sniff: assert property (@(posedge ref_clk) disable iff (reset)
    rx_sniff == $past(f_rx_sniff))
    else $error("receive sniff output stale");

  a_cfg_tx_sniff: assert property (@(posedge ref_clk) disable iff (reset)
    tx_sniff == $past(f_tx_sniff))
    else $error("transmit sniff output stale");

  a_cfg_ceiling: assert property (@(posedge ref_clk) disable iff (reset)
    prio_ceiling == $past(f_ceiling))
    else $error("priority ceiling output stale");

  c_learn_blocked: cover property (@(posedge ref_clk) disable iff (reset)
    rx_take && f_learn_dis);
  c_rx_mirrored: cover property (@(posedge ref_clk) disable iff (reset)
    fwd_valid && fwd_monitored);
  c_prio_clamped: cover property (@(posedge ref_clk) disable iff (reset)
    rx_take && clamp_hit);
  c_tx_off_then_on: cover property (@(posedge ref_clk) disable iff (reset)
    tx_req && !f_tx_en ##[1:20] tx_grant);
  c_mon_sent: cover property (@(posedge ref_clk) disable iff (reset) mon_grant);

endmodule : host_port_forwarding_control
